// ==== src/sdram_rd_pkg.sv ====
package sdram_rd_pkg;
	// Interface cycles between the read command and the first data beat
	localparam int CAS_LATENCY = 3;
	// Idle interface cycles between row activate and read command
	localparam int RCD_NOPS = 1;
	// Interface cycles after the last beat: strobe drain and auto-precharge recovery
	localparam int TAIL_TICKS = 3;
	localparam int LAT_W = 2;
	localparam logic [LAT_W-1:0] LAT_RESET = 2'h0;
	// Column address bit that requests auto-precharge with the read
	localparam int AUTO_PRE_BIT = 10;
	// Command encodings as {row, column, write} strobe levels
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACTV = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic SYNC_RESET = 1'h0;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ACT = 7'h02,
		ST_RCD = 7'h04,
		ST_READ = 7'h08,
		ST_CL = 7'h10,
		ST_DATA = 7'h20,
		ST_TAIL = 7'h40
	} rd_state_e;
endpackage : sdram_rd_pkg

// ==== src/sdram_read_direct_transfer.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_read_direct_transfer #(
	parameter int ROW_W = 13,
	parameter int COL_W = 10,
	parameter int BANK_W = 2,
	parameter int DATA_W = 16,
	parameter int BEATS = 4,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic ref_clk, // Block clock, 25 MHz
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic interface_clock_out, // Interface clock as seen at the pin
	input wire logic req_valid, // Read request offered
	output logic req_ready, // Request can be taken
	input wire logic [BANK_W-1:0] req_bank, // Bank of the read
	input wire logic [ROW_W-1:0] req_row, // Row of the read
	input wire logic [COL_W-1:0] req_col, // First column of the burst
	input wire logic direct_transfer_select_bit, // 1 selects direct-transfer mode
	input wire logic [1:0] direct_read_latency, // Strobe delay in interface cycles
	input wire logic alt_strobe_a_n, // Shared pin A function outside SDRAM access
	input wire logic alt_strobe_b_n, // Shared pin B function outside SDRAM access
	input wire logic alt_strobe_c_n, // Shared pin C function outside SDRAM access
	output logic shared_strobe_a_n, // Pin A, column strobe during SDRAM access
	output logic shared_strobe_b_n, // Pin B, write strobe during SDRAM access
	output logic shared_strobe_c_n, // Pin C, row strobe during SDRAM access
	output logic chip_select_n, // SDRAM chip select
	output logic [BANK_W-1:0] bank_addr, // SDRAM bank address
	output logic [ROW_W-1:0] mem_addr, // SDRAM row or column address
	input wire logic [DATA_W-1:0] mem_data_in, // Data bus from the SDRAM
	output logic direct_transfer_strobe, // Direct-transfer strobe, active high
	output logic rd_valid, // Captured word available
	input wire logic rd_ready, // Consumer takes the word
	output logic [DATA_W-1:0] rd_data // Captured word
);
	localparam int FAW = $clog2(FIFO_DEPTH);

	sdram_rd_pkg::rd_state_e state_q, state_d;
	logic [2:0] clk_sync_q;
	logic clk_level_q;
	logic [DATA_W-1:0] data_s0_q, data_s1_q, data_s2_q;
	logic [3:0] cnt_q, cnt_d;
	logic [BANK_W-1:0] bank_q;
	logic [ROW_W-1:0] row_q;
	logic [COL_W-1:0] col_q;
	logic direct_q;
	logic [1:0] lat_q;
	logic [2:0] hist_q;
	logic strobe_q;
	logic [2:0] cmd_q;
	logic cs_n_q;
	logic [ROW_W-1:0] addr_q;
	logic [BANK_W-1:0] ba_q;
	logic pin_a_q, pin_b_q, pin_c_q;
	logic req_ready_q;
	logic fifo_in_ready;
	logic [FAW:0] fifo_level;

	// Edge found only once the second and third stage agree on the new level
	wire clk_stable = (clk_sync_q[1] == clk_sync_q[2]);
	wire tick = clk_stable && clk_sync_q[2] && !clk_level_q;
	wire accept = req_valid && req_ready_q;
	wire in_data_phase = (state_q == sdram_rd_pkg::ST_DATA);
	wire dphase_dir = in_data_phase && direct_q;
	wire capture = tick && in_data_phase && !direct_q;
	wire push = capture && fifo_in_ready;
	wire last_beat = (cnt_q == 4'(BEATS - 1));
	wire room_ok = (fifo_level <= (FAW + 1)'(FIFO_DEPTH - BEATS));
	wire sdram_active = (state_q != sdram_rd_pkg::ST_IDLE);

	// Strobe tap: latency 0 follows the data phase itself, else the delay line
	wire strobe_d = (lat_q == 2'h0) ? dphase_dir : hist_q[lat_q - 2'h1];

	wire [2:0] cmd_d = !tick ? cmd_q :
		(state_q == sdram_rd_pkg::ST_ACT) ? sdram_rd_pkg::CMD_ACTV :
		(state_q == sdram_rd_pkg::ST_READ) ? sdram_rd_pkg::CMD_READ :
		sdram_rd_pkg::CMD_NOP;
	wire [ROW_W-1:0] col_addr = ROW_W'(col_q) | (ROW_W'(1) << sdram_rd_pkg::AUTO_PRE_BIT);
	wire [ROW_W-1:0] addr_d = !tick ? addr_q :
		(state_q == sdram_rd_pkg::ST_ACT) ? row_q :
		(state_q == sdram_rd_pkg::ST_READ) ? col_addr : addr_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			sdram_rd_pkg::ST_IDLE: begin
				if (accept) begin
					state_d = sdram_rd_pkg::ST_ACT;
				end
			end
			sdram_rd_pkg::ST_ACT: begin
				if (tick) begin
					state_d = sdram_rd_pkg::ST_RCD;
					cnt_d = 4'(sdram_rd_pkg::RCD_NOPS - 1);
				end
			end
			sdram_rd_pkg::ST_RCD: begin
				if (tick) begin
					if (cnt_q == 4'h0) begin
						state_d = sdram_rd_pkg::ST_READ;
					end else begin
						cnt_d = cnt_q - 4'h1;
					end
				end
			end
			sdram_rd_pkg::ST_READ: begin
				if (tick) begin
					state_d = sdram_rd_pkg::ST_CL;
					cnt_d = 4'(sdram_rd_pkg::CAS_LATENCY - 2);
				end
			end
			sdram_rd_pkg::ST_CL: begin
				if (tick) begin
					if (cnt_q == 4'h0) begin
						state_d = sdram_rd_pkg::ST_DATA;
						cnt_d = 4'h0;
					end else begin
						cnt_d = cnt_q - 4'h1;
					end
				end
			end
			sdram_rd_pkg::ST_DATA: begin
				if (tick) begin
					if (last_beat) begin
						state_d = sdram_rd_pkg::ST_TAIL;
						cnt_d = 4'(sdram_rd_pkg::TAIL_TICKS - 1);
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
			end
			sdram_rd_pkg::ST_TAIL: begin
				// Long enough for strobes at latency 0 to 2 to finish; at latency 3 the strobe falls on the first tick after the tail
				if (tick) begin
					if (cnt_q == 4'h0) begin
						state_d = sdram_rd_pkg::ST_IDLE;
					end else begin
						cnt_d = cnt_q - 4'h1;
					end
				end
			end
			default: begin
				state_d = sdram_rd_pkg::ST_IDLE;
				cnt_d = 4'h0;
			end
		endcase
	end

	// Pin samplers; the data bus uses its third stage, stable long before the tick
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			clk_sync_q <= 3'h0;
			clk_level_q <= 1'b0;
			data_s0_q <= '0;
			data_s1_q <= '0;
			data_s2_q <= '0;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], interface_clock_out};
			if (clk_stable) clk_level_q <= clk_sync_q[2];
			data_s0_q <= mem_data_in;
			data_s1_q <= data_s0_q;
			data_s2_q <= data_s1_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_q <= sdram_rd_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			req_ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			// Stale by a cycle only while the level can only fall, so never optimistic
			req_ready_q <= (state_d == sdram_rd_pkg::ST_IDLE) && room_ok;
		end
	end

	// Transfer options are frozen for the whole burst
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			bank_q <= '0;
			row_q <= '0;
			col_q <= '0;
			direct_q <= 1'b0;
			lat_q <= sdram_rd_pkg::LAT_RESET;
		end else if (accept) begin
			bank_q <= req_bank;
			row_q <= req_row;
			col_q <= req_col;
			direct_q <= direct_transfer_select_bit;
			lat_q <= direct_read_latency;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hist_q <= 3'h0;
			strobe_q <= 1'b0;
		end else if (tick) begin
			hist_q <= {hist_q[1:0], dphase_dir};
			strobe_q <= strobe_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cmd_q <= sdram_rd_pkg::CMD_NOP;
			cs_n_q <= 1'b1;
			addr_q <= '0;
			ba_q <= '0;
		end else begin
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			if (tick) begin
				cs_n_q <= (cmd_d == sdram_rd_pkg::CMD_NOP);
				ba_q <= bank_q;
			end
		end
	end

	// Shared pins take their SDRAM roles for the whole access
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_a_q <= 1'b1;
			pin_b_q <= 1'b1;
			pin_c_q <= 1'b1;
		end else begin
			pin_a_q <= sdram_active ? cmd_q[1] : alt_strobe_a_n;
			pin_b_q <= sdram_active ? cmd_q[0] : alt_strobe_b_n;
			pin_c_q <= sdram_active ? cmd_q[2] : alt_strobe_c_n;
		end
	end

	stream_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(data_s2_q),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data),
		.level(fifo_level)
	);

	assign req_ready = req_ready_q;
	assign shared_strobe_a_n = pin_a_q;
	assign shared_strobe_b_n = pin_b_q;
	assign shared_strobe_c_n = pin_c_q;
	assign chip_select_n = cs_n_q;
	assign bank_addr = ba_q;
	assign mem_addr = addr_q;
	assign direct_transfer_strobe = strobe_q;
endmodule : sdram_read_direct_transfer
`default_nettype wire

// ==== src/stream_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic ref_clk, // Block clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic in_valid, // Write word offered
	output logic in_ready, // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Word to store
	output logic out_valid, // Output register holds a word
	input wire logic out_ready, // Consumer takes the word
	output logic [WIDTH-1:0] out_data, // Registered read data
	output logic [AW:0] level // Words in storage, output stage excluded
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	wire push = in_valid && in_ready;
	wire pop = (count_q != '0) && (!out_valid_q || out_ready);
	wire [AW-1:0] wr_next = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
	wire [AW-1:0] rd_next = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

	assign in_ready = (count_q != (AW + 1)'(DEPTH));
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign level = count_q;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else begin
			if (push) wr_ptr_q <= wr_next;
			if (pop) rd_ptr_q <= rd_next;
			count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
			if (pop) begin
				out_data_q <= mem_q[rd_ptr_q];
				out_valid_q <= 1'b1;
			end else if (out_ready) begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule : stream_fifo
`default_nettype wire

// ==== tb/sdram_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_partner (
	input wire logic interface_clock_out, // Link clock
	input wire logic shared_strobe_a_n, // Column
	input wire logic shared_strobe_c_n, // Row
	input wire logic chip_select_n, // Select
	input wire logic [12:0] mem_addr, // Address
	output logic [15:0] mem_data_in // Data bus
);
	logic [9:0] col_q = 10'h0;
	int phase = 0;
	logic [15:0] bus_q = 16'h0;
	assign mem_data_in = bus_q;
	always @(posedge interface_clock_out) begin
		if (!chip_select_n && !shared_strobe_a_n && shared_strobe_c_n) begin
			col_q <= mem_addr[9:0];
			phase <= 1;
		end else if (phase > 0) begin
			phase <= (phase == 5) ? 0 : phase + 1;
		end
	end
	// Words sit centred on the rise two cycles after the command; else noise
	always @(negedge interface_clock_out) begin
		if (phase >= 2) bus_q <= {6'h2a, col_q + 10'(phase - 2)};
		else bus_q <= ~bus_q;
	end
endmodule : sdram_partner
`default_nettype wire

// ==== tb/sdram_read_direct_transfer_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_read_direct_transfer_monitor #(
	parameter int ROW_W = 13
) (
	input wire logic ref_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic req_valid, // Offer
	input wire logic req_ready, // Accept
	input wire logic direct_transfer_select_bit, // Mode
	input wire logic [1:0] direct_read_latency, // Delay
	input wire logic shared_strobe_a_n, // Column
	input wire logic shared_strobe_b_n, // Write
	input wire logic shared_strobe_c_n, // Row
	input wire logic chip_select_n, // Select
	input wire logic [ROW_W-1:0] mem_addr, // Address
	input wire logic direct_transfer_strobe // Strobe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_read_cmd;
		!$past(chip_select_n) && $fell(shared_strobe_a_n);
	endsequence
	sequence s_zero_lat;
		direct_transfer_select_bit && direct_read_latency == 2'h0;
	endsequence
	property p_write_high; !chip_select_n |=> shared_strobe_b_n; endproperty
	a_write_high: assert property (p_write_high) else $error("write strobe low");
	property p_one_strobe; !chip_select_n |=> shared_strobe_a_n != shared_strobe_c_n; endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("bad command");
	property p_autopre; s_read_cmd |-> $past(mem_addr[sdram_rd_pkg::AUTO_PRE_BIT]); endproperty
	a_autopre: assert property (p_autopre) else $error("read lacks bit");
	property p_ready_drop; req_valid && req_ready |=> !req_ready [*8]; endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready stayed");
	property p_cs_len; $fell(chip_select_n) |-> !chip_select_n [*6] ##[1:3] chip_select_n; endproperty
	a_cs_len: assert property (p_cs_len) else $error("select length");
	property p_cs_idle; !chip_select_n |-> !req_ready; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("ready in access");
	property p_dts_len;
		$rose(direct_transfer_strobe) |-> direct_transfer_strobe [*8] ##[22:26] !direct_transfer_strobe;
	endproperty
	a_dts_len: assert property (p_dts_len) else $error("strobe length");
	property p_cas_zero;
		s_read_cmd ##0 s_zero_lat |-> ##[22:24] $rose(direct_transfer_strobe);
	endproperty
	a_cas_zero: assert property (p_cas_zero) else $error("strobe timing");
endmodule : sdram_read_direct_transfer_monitor
bind sdram_read_direct_transfer sdram_read_direct_transfer_monitor #(.ROW_W(ROW_W)) u_mon (
	.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
	.direct_transfer_select_bit(direct_transfer_select_bit),
	.direct_read_latency(direct_read_latency), .shared_strobe_a_n(shared_strobe_a_n),
	.shared_strobe_b_n(shared_strobe_b_n), .shared_strobe_c_n(shared_strobe_c_n),
	.chip_select_n(chip_select_n), .mem_addr(mem_addr),
	.direct_transfer_strobe(direct_transfer_strobe));
`default_nettype wire

// ==== tb/sdram_read_direct_transfer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_read_direct_transfer_tb;
	logic ref_clk = 1'b0, if_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, sel = 1'b0;
	logic [1:0] req_bank = 2'h0, lat = 2'h0, bank, act_bank = 2'h0;
	logic [12:0] req_row = 13'h0, addr, act_row = 13'h0;
	logic [9:0] req_col = 10'h0;
	logic alt_a = 1'b1, alt_b = 1'b1, alt_c = 1'b1, rd_ready = 1'b1;
	logic req_ready, pin_a, pin_b, pin_c, cs_n, dts, rd_valid;
	logic [15:0] mdata, rd_data;
	int n_fail = 0, tests_run = 0, cyc = 0, n_dts = 0;
	always #20 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #160 if_clk = ~if_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		// Counted here only, so the scenarios take snapshots instead of clearing it
		if (dts === 1'b1) n_dts <= n_dts + 1;
		if (cs_n === 1'b0 && pin_c === 1'b0) begin
			act_row <= addr;
			act_bank <= bank;
		end
	end
	sdram_read_direct_transfer DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.interface_clock_out(if_clk), .req_valid(req_valid), .req_ready(req_ready),
		.req_bank(req_bank), .req_row(req_row), .req_col(req_col),
		.direct_transfer_select_bit(sel), .direct_read_latency(lat), .alt_strobe_a_n(alt_a),
		.alt_strobe_b_n(alt_b), .alt_strobe_c_n(alt_c), .shared_strobe_a_n(pin_a),
		.shared_strobe_b_n(pin_b), .shared_strobe_c_n(pin_c), .chip_select_n(cs_n),
		.bank_addr(bank), .mem_addr(addr), .mem_data_in(mdata), .direct_transfer_strobe(dts),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
	sdram_partner u_mem (.interface_clock_out(if_clk), .shared_strobe_a_n(pin_a),
		.shared_strobe_c_n(pin_c), .chip_select_n(cs_n), .mem_addr(addr), .mem_data_in(mdata));
	task print_verdict;
		if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task give_up;
		n_fail++;
		print_verdict();
	endtask : give_up
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wait_lvl(input int which, input logic v, output int at);
		logic s;
		for (int k = 0; k <= 600; k++) begin
			if (k == 600) give_up();
			@(posedge ref_clk);
			s = (which == 0) ? pin_a : (which == 1) ? dts : rd_valid;
			at = cyc;
			if (s === v) break;
		end
	endtask : wait_lvl
	task issue(input logic [12:0] row, input logic [9:0] col, input logic s, input logic [1:0] l);
		int at;
		tick(1);
		{req_bank, req_row, req_col, sel, lat, req_valid} = {row[12:11], row, col, s, l, 1'b1};
		// Request and its fields stand until the edge where ready is seen high
		for (int k = 0; k <= 300; k++) begin
			if (k == 300) give_up();
			@(posedge ref_clk);
			if (req_ready === 1'b1) break;
		end
		#1 req_valid = 1'b0;
	endtask : issue
	task automatic pop_check(input logic [9:0] col);
		int at;
		for (int i = 0; i < 4; i++) begin
			wait_lvl(2, 1'b1, at);
			check(rd_data, {6'h2a, col + 10'(i)});
		end
		// Leave the edge so the caller never drives an input in its time step
		#1;
	endtask : pop_check
	task t_capture;
		int n0;
		{alt_a, alt_b, alt_c} = 3'b010;
		tick(3);
		check({pin_a, pin_b, pin_c}, 3'b010);
		{alt_a, alt_b, alt_c} = 3'b111;
		n0 = n_dts;
		issue(13'h1abc, 10'h0fc, 1'b0, 2'h3);
		pop_check(10'h0fc);
		check(act_row, 13'h1abc);
		check(act_bank, 2'h3);
		check(16'(n_dts - n0), 16'h0);
	endtask : t_capture
	task t_fill;
		rd_ready = 1'b0;
		issue(13'h0055, 10'h010, 1'b0, 2'h0);
		issue(13'h0aa0, 10'h020, 1'b0, 2'h0);
		tick(150);
		// Two bursts leave too little room for a third, so ready must stay low
		check(req_ready, 1'b0);
		rd_ready = 1'b1;
		pop_check(10'h010);
		pop_check(10'h020);
		tick(3);
		check(rd_valid, 1'b0);
	endtask : t_fill
	task automatic t_direct(input logic [1:0] l);
		int c0, c1, c2;
		issue(13'h0123, 10'h040, 1'b1, l);
		wait_lvl(0, 1'b0, c0);
		wait_lvl(1, 1'b1, c1);
		wait_lvl(1, 1'b0, c2);
		check(16'(c1 - c0 >= 22 + 8 * l && c1 - c0 <= 24 + 8 * l), 16'h1);
		check(16'(c2 - c1 >= 31 && c2 - c1 <= 33), 16'h1);
		tick(150);
		check(rd_valid, 1'b0);
	endtask : t_direct
	initial begin
		repeat (12) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		t_capture();
		t_fill();
		for (int l = 0; l < 4; l++) t_direct(2'(l));
		print_verdict();
	end
endmodule : sdram_read_direct_transfer_tb
`default_nettype wire
